// file: verilog/eeprom_pkg.sv
// Constants and carrier types shared by the two-wire EEPROM slave
package eeprom_pkg;
  // Clock rate and transmit hold time after a clock fall
  localparam int CLK_MHZ = 200;
  localparam int TX_HOLD_NS = 300;
  localparam int HOLD_CYC = (TX_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY_W = 7;
  // Self-timed write cycle length
  localparam int T_WR_MS = 5;
  localparam int WR_CYC = T_WR_MS * 1000 * 1000 / (1000 / CLK_MHZ);
  // Pin sampling: scl, sda, then three select straps
  localparam int SYNC_W = 5;
  localparam logic [4:0] SYNC_RST = 5'h03;
  localparam int SCL_IDX = 0;
  localparam int SDA_IDX = 1;
  localparam int SEL_LO = 2;
  localparam int SEL_HI = 4;
  // Word address and page geometry
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam logic [11:0] PTR_RST = 12'h000;
  // Byte framing and control byte fields
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;
  localparam int CODE_HI = 7;
  localparam int CODE_LO = 4;
  localparam int CSEL_HI = 3;
  localparam int CSEL_LO = 1;
  localparam int DIR_BIT = 0;
  localparam logic DIR_READ = 1'b1;
  // Device type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
  // Bus sequencing and write-cycle states
  typedef enum logic [2:0] {B_IDLE, B_CTRL, B_AHI, B_ALO, B_DATA, B_SKIP} bus_st_t;
  typedef enum logic [1:0] {C_IDLE, C_SCAN, C_WAIT} cm_st_t;
  // One received data byte and its slot in the page
  typedef struct packed {
    logic [PAGE_W-1:0] idx;
    logic [7:0] data;
  } rx_word_t;
endpackage : eeprom_pkg

// file: verilog/page_buffer.sv
// Page buffer memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module page_buffer #(
  parameter int WIDTH = 8, // Word width
  parameter int DEPTH = 32, // Number of words
  parameter int AW = 5 // Address width
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [WIDTH-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [WIDTH-1:0] rdata // Read data, one cycle late
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  // Storage carries no reset; the read port samples any slot, written or not
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Read register clears the output in reset, then follows the addressed word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

  assign rdata = rdata_q;
endmodule : page_buffer
`default_nettype wire

// file: verilog/skid_fifo.sv
// Small valid/ready buffer between the bit engine and the page buffer
`timescale 1ns/100ps
`default_nettype none
module skid_fifo #(
  parameter int WIDTH = 13, // Word width
  parameter int DEPTH = 2 // Number of entries
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Offered word
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain accepts the word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at DEPTH, which need not be a power of two
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (push) begin
      wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Entry storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule : skid_fifo
`default_nettype wire

// file: verilog/eeprom_twowire_slave.sv
// Two-wire serial EEPROM slave: framing, addressing, page buffer, write cycle
// Notes on behaviour
// - Data stays stable while clock high; changes then mean START or STOP.
// - Data falling while clock high is taken as START.
// - Data rising while clock high is taken as STOP.
// - One clock pulse per bit; data changes only while clock low.
// - Every byte received while addressed is acknowledged on a ninth pulse.
// - No acknowledge at all while the internal write cycle runs.
// - Acknowledge holds data low through the whole ninth clock high phase.
// - On a read the slave leaves data high after the master's no-ack.
// - First byte after START is type code, three selects, direction.
// - Control byte acknowledged only on code and select match; direction chosen.
// - After write control, high then low address bytes load, each acknowledged.
// - Bytes arrive most significant bit first, high address byte first.
// - Data byte acknowledged; following STOP starts the self-timed write.
// - Up to 32 data bytes buffered, committed to the array after STOP.
// - Only low five pointer bits step per byte; excess bytes overwrite.
// - Page write wraps to start of its own aligned page.
// - Polling with write control gets no-ack while busy, ack after.
// - Data line changes only a minimum hold after each clock fall.
`timescale 1ns/100ps
`default_nettype none
module eeprom_twowire_slave
  import eeprom_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF, // Type code; value is arbitrary
  parameter int WR_CYCLES = WR_CYC, // Self-timed write length in cycles
  parameter int TX_HOLD = HOLD_CYC // Hold after clock fall in cycles
) (
  input wire logic mclk, // 200 MHz system clock
  input wire logic rst, // Async reset, active high
  input wire logic scl_in, // Serial clock pin
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Data pin drive value, always low
  output logic sda_oe_n, // Data pin enable, low pulls line low
  input wire logic [2:0] chip_select_straps, // Strapped select levels
  output logic write_busy, // Internal write cycle in progress
  output logic arr_we, // Array write strobe
  output logic [ADDR_W-1:0] arr_addr, // Array write address
  output logic [7:0] arr_data // Array write data
);
  localparam int TW = $clog2(WR_CYCLES + 1);

  // Pin sampling: three flops, then a change counts once two agree
  logic [SYNC_W-1:0] pin_w, s1_q, s2_q, s3_q, flt_q, flt_d;
  assign pin_w = {chip_select_straps, sda_in, scl_in};

  genvar g;
  for (g = 0; g < SYNC_W; g++) begin : g_flt
    assign flt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      flt_q <= SYNC_RST;
    end else begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  // Bus events, seen one cycle before the filtered level registers
  logic scl_rise, scl_fall, start_det, stop_det, sda_f;
  logic [2:0] sel_f;
  assign sda_f = flt_q[SDA_IDX];
  assign sel_f = flt_q[SEL_HI:SEL_LO];
  assign scl_rise = flt_d[SCL_IDX] & ~flt_q[SCL_IDX];
  assign scl_fall = ~flt_d[SCL_IDX] & flt_q[SCL_IDX];
  assign start_det = flt_q[SCL_IDX] & flt_d[SCL_IDX] & sda_f & ~flt_d[SDA_IDX];
  assign stop_det = flt_q[SCL_IDX] & flt_d[SCL_IDX] & ~sda_f & flt_d[SDA_IDX];

  // Buffer and page memory links
  rx_word_t f_in, f_word;
  logic [$bits(rx_word_t)-1:0] f_out;
  logic f_iv, f_ir, f_ov, f_or;
  assign f_word = f_out;

  // Bus sequencing state
  bus_st_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic ack_q, ack_d, drv_q, drv_d, oe_q, oe_d, commit_go;
  logic [DLY_W-1:0] dly_q, dly_d, since_q, since_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d;

  // Write-cycle state
  cm_st_t cm_q, cm_d;
  logic [5:0] cidx_q, cidx_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [PAGE_BYTES-1:0] mask_q, mask_d;
  logic busy_q, busy_d, we_q, we_d;
  logic [ADDR_W-1:0] addr_q, addr_d;

  // Bit engine: shifting, byte decisions, acknowledge drive and pointer
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ack_d = ack_q;
    drv_d = drv_q;
    oe_d = oe_q;
    ptr_d = ptr_q;
    f_iv = 1'b0;
    f_in = '{idx: ptr_q[PAGE_W-1:0], data: sh_q};
    commit_go = 1'b0;
    dly_d = dly_q;
    since_d = (since_q == '1) ? since_q : since_q + 7'h01;
    if (scl_fall) begin
      since_d = '0;
    end
    if (dly_q != '0) begin
      dly_d = dly_q - 7'h01;
    end
    if (dly_q == 7'h01) begin
      oe_d = ~drv_q;
    end
    if (scl_rise && bit_q < ACK_BIT) begin
      sh_d = {sh_q[6:0], sda_f};
      bit_d = bit_q + 4'h1;
      if (bit_q == LAST_BIT) begin
        f_in = '{idx: ptr_q[PAGE_W-1:0], data: sh_d};
        unique case (st_q)
          B_CTRL: begin
            ack_d = (sh_d[CODE_HI:CODE_LO] == DEV_TYPE) &&
                    (sh_d[CSEL_HI:CSEL_LO] == sel_f) && !busy_q;
            if (!ack_d) begin
              st_d = B_SKIP;
            end else if (sh_d[DIR_BIT] == DIR_READ) begin
              st_d = B_SKIP;
            end else begin
              st_d = B_AHI;
            end
          end
          B_AHI: begin
            ack_d = 1'b1;
            ptr_d[ADDR_W-1:8] = sh_d[3:0];
            st_d = B_ALO;
          end
          B_ALO: begin
            ack_d = 1'b1;
            ptr_d[7:0] = sh_d;
            st_d = B_DATA;
          end
          B_DATA: begin
            f_iv = 1'b1;
            ack_d = f_ir;
            if (f_ir) begin
              ptr_d[PAGE_W-1:0] = ptr_q[PAGE_W-1:0] + 5'h01;
            end
          end
          B_IDLE, B_SKIP: begin
            ack_d = 1'b0;
          end
        endcase
      end
    end else if (scl_rise) begin
      bit_d = ACK_DONE;
    end
    if (scl_fall && bit_q == ACK_BIT) begin
      drv_d = ack_q;
      dly_d = 7'(TX_HOLD);
    end
    if (scl_fall && bit_q == ACK_DONE) begin
      drv_d = 1'b0;
      dly_d = 7'(TX_HOLD);
      bit_d = '0;
    end
    if (start_det) begin
      st_d = B_CTRL;
      bit_d = '0;
      ack_d = 1'b0;
      drv_d = 1'b0;
      oe_d = 1'b1;
      dly_d = '0;
    end
    if (stop_det) begin
      st_d = B_IDLE;
      bit_d = '0;
      ack_d = 1'b0;
      drv_d = 1'b0;
      oe_d = 1'b1;
      dly_d = '0;
      commit_go = (st_q == B_DATA) && ((mask_q != '0) || f_ov) && !busy_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= B_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      oe_q <= 1'b1;
      dly_q <= '0;
      since_q <= '0;
      ptr_q <= PTR_RST;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ack_q <= ack_d;
      drv_q <= drv_d;
      oe_q <= oe_d;
      dly_q <= dly_d;
      since_q <= since_d;
      ptr_q <= ptr_d;
    end
  end

  // The page buffer drains this buffer only while the scan index is zero
  skid_fifo #(
    .WIDTH($bits(rx_word_t)),
    .DEPTH(2)
  ) u_fifo (
    .clk(mclk),
    .rst(rst),
    .in_valid(f_iv),
    .in_ready(f_ir),
    .in_data(f_in),
    .out_valid(f_ov),
    .out_ready(f_or),
    .out_data(f_out)
  );

  page_buffer #(
    .WIDTH(8),
    .DEPTH(PAGE_BYTES),
    .AW(PAGE_W)
  ) u_pbuf (
    .clk(mclk),
    .rst(rst),
    .we(f_ov & f_or),
    .waddr(f_word.idx),
    .wdata(f_word.data),
    .raddr(cidx_q[PAGE_W-1:0]),
    .rdata(arr_data)
  );

  // Commit: scan the page, emit marked bytes, then hold busy for the write time
  always_comb begin
    cm_d = cm_q;
    cidx_d = cidx_q;
    tmr_d = tmr_q;
    mask_d = mask_q;
    we_d = 1'b0;
    addr_d = addr_q;
    f_or = (cidx_q == '0);
    if (f_ov && f_or) begin
      mask_d[f_word.idx] = 1'b1;
    end
    unique case (cm_q)
      C_IDLE: begin
        if (commit_go) begin
          cm_d = C_SCAN;
        end
      end
      C_SCAN: begin
        if (cidx_q == 6'(PAGE_BYTES)) begin
          cm_d = C_WAIT;
          cidx_d = '0;
          mask_d = '0;
          tmr_d = TW'(WR_CYCLES - 1);
        end else if (!f_ov) begin
          we_d = mask_q[cidx_q[PAGE_W-1:0]];
          addr_d = {ptr_q[ADDR_W-1:PAGE_W], cidx_q[PAGE_W-1:0]};
          cidx_d = cidx_q + 6'h01;
        end
      end
      C_WAIT: begin
        if (tmr_q == '0) begin
          cm_d = C_IDLE;
        end else begin
          tmr_d = tmr_q - TW'(1);
        end
      end
    endcase
    busy_d = (cm_d != C_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cm_q <= C_IDLE;
      cidx_q <= '0;
      tmr_q <= '0;
      mask_q <= '0;
      busy_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= '0;
    end else begin
      cm_q <= cm_d;
      cidx_q <= cidx_d;
      tmr_q <= tmr_d;
      mask_q <= mask_d;
      busy_q <= busy_d;
      we_q <= we_d;
      addr_q <= addr_d;
    end
  end

  // Open-drain pin: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_q;
  assign write_busy = busy_q;
  assign arr_we = we_q;
  assign arr_addr = addr_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_tx_hold:
    assert property ($fell(oe_q) |-> since_q >= 7'(TX_HOLD))
    else $error("data driven too soon after clock fall");
  chk_busy_nack:
    assert property (busy_q |-> oe_q)
    else $error("line driven during write cycle");
  chk_start_ctrl:
    assert property (start_det |=> st_q == B_CTRL && bit_q == 4'h0 && ptr_q == $past(ptr_q))
    else $error("START did not restart control reception");
  chk_stop_idle:
    assert property (stop_det |=> st_q == B_IDLE && oe_q)
    else $error("STOP not honoured");
  chk_ack_hold:
    assert property (bit_q == ACK_DONE && ack_q && flt_q[SCL_IDX] |-> !oe_q)
    else $error("acknowledge not low in clock high");
  chk_ctrl_match:
    assert property (scl_rise && bit_q == LAST_BIT && st_q == B_CTRL |=>
      ack_q == (sh_q[CODE_HI:CODE_LO] == DEV_TYPE &&
      sh_q[CSEL_HI:CSEL_LO] == $past(sel_f) && !$past(busy_q)))
    else $error("control byte decision wrong");
  chk_addr_load:
    assert property (scl_rise && bit_q == LAST_BIT && st_q == B_ALO |=>
      ptr_q[7:0] == sh_q && st_q == B_DATA)
    else $error("low address byte not loaded");
  chk_ptr_wrap:
    assert property (f_iv && f_ir |=> ptr_q[PAGE_W-1:0] == $past(ptr_q[PAGE_W-1:0]) + 5'h01
      && ptr_q[ADDR_W-1:PAGE_W] == $past(ptr_q[ADDR_W-1:PAGE_W]))
    else $error("pointer step wrong");
  chk_commit_stop:
    assert property (commit_go |=> cm_q == C_SCAN && busy_q)
    else $error("STOP did not start write cycle");
  chk_we_scan:
    assert property (we_q |-> $past(cm_q) == C_SCAN)
    else $error("array written outside commit");

  cov_commit: cover property (commit_go);
  cov_poll_nack: cover property (scl_rise && bit_q == LAST_BIT && st_q == B_CTRL && busy_q);
  cov_wrap: cover property (f_iv && f_ir && ptr_q[PAGE_W-1:0] == 5'h1F);
  cov_ack: cover property ($fell(oe_q));
endmodule : eeprom_twowire_slave
`default_nettype wire

// file: verif/twowire_master.sv
// Two-wire bus master model that paces the serial clock from the system clock
`timescale 1ns/100ps
`default_nettype none
module twowire_master (
  output logic scl, // Serial clock, idles high
  output logic sda_drv_n, // Low pulls the data line low
  input wire logic sda_line, // Resolved data level
  input wire logic mclk // Pacing clock
);
  // Quarter of a 160 ns bit at 5 ns per cycle
  localparam int QTR = 8;
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  // Changes land on the falling edge, away from the sampling edge
  task automatic pace(input int n);
    repeat (n) @(negedge mclk);
  endtask : pace
  // start from idle or as repeat
  task automatic start_cond();
    pace(QTR);
    sda_drv_n = 1'b1;
    pace(QTR);
    scl = 1'b1;
    pace(2 * QTR);
    sda_drv_n = 1'b0;
    pace(2 * QTR);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    pace(QTR);
    sda_drv_n = 1'b0;
    pace(QTR);
    scl = 1'b1;
    pace(2 * QTR);
    sda_drv_n = 1'b1;
    pace(2 * QTR);
  endtask : stop_cond
  // data set mid low phase, first bit is the top one
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      pace(QTR);
      sda_drv_n = b[i];
      pace(QTR);
      scl = 1'b1;
      pace(2 * QTR);
      scl = 1'b0;
    end
  endtask : send_bits
  // ninth pulse: line sampled early, late and just after the fall
  task automatic send_byte(input logic [7:0] b, output logic [2:0] smp);
    send_bits(b, 8);
    pace(QTR);
    sda_drv_n = 1'b1;
    pace(QTR);
    scl = 1'b1;
    pace(1);
    smp[2] = sda_line;
    pace(2 * QTR - 2);
    smp[1] = sda_line;
    pace(1);
    scl = 1'b0;
    pace(2);
    smp[0] = sda_line;
  endtask : send_byte
endmodule : twowire_master
`default_nettype wire

// file: verif/tb_eeprom_twowire_slave.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/100ps
`default_nettype none
module tb_eeprom_twowire_slave;
  import eeprom_pkg::*;
  // Type code; value is arbitrary
  localparam logic [3:0] CODE = 4'h6;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam logic [7:0] WR_CTRL = {CODE, STRAPS, 1'b0};
  logic mclk, rst, scl, sda_drv_n, sda_line, sda_out, sda_oe_n, write_busy, arr_we;
  logic [2:0] straps;
  logic [11:0] arr_addr;
  logic [7:0] arr_data;
  logic [7:0] seen [logic [11:0]];
  int error_cnt, compares;
  // Open-drain line with pull-up: low if either party pulls
  assign sda_line = sda_drv_n & (sda_oe_n ? 1'b1 : sda_out);
  eeprom_twowire_slave #(.DEV_TYPE(CODE), .WR_CYCLES(2000), .TX_HOLD(5)) dut (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .chip_select_straps(straps), .write_busy(write_busy),
    .arr_we(arr_we), .arr_addr(arr_addr), .arr_data(arr_data));
  twowire_master m (.scl(scl), .sda_drv_n(sda_drv_n), .sda_line(sda_line), .mclk(mclk));
  always #2.5 mclk = ~mclk;
  // Record every array write so a stray or missing commit shows
  always @(posedge mclk) begin
    if (arr_we === 1'b1) begin
      seen[arr_addr] = arr_data;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_busy === 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      $display("ERROR write_busy expected 0 seen 1");
      test_done();
    end
  endtask : wait_idle
  task automatic write_seq(input logic [11:0] addr, input int n, input logic [7:0] base);
    logic [2:0] smp;
    m.start_cond();
    m.send_byte(WR_CTRL, smp);
    chk("ctrl ack", 3'b000, smp);
    m.send_byte({4'h0, addr[11:8]}, smp);
    chk("addr hi ack", 3'b000, smp);
    m.send_byte(addr[7:0], smp);
    chk("addr lo ack", 3'b000, smp);
    for (int k = 0; k < n; k++) begin
      m.send_byte(base + 8'(k), smp);
      chk("data ack", 3'b000, smp);
    end
    m.stop_cond();
  endtask : write_seq
  task automatic t_reset();
    chk("oe_n in reset", 1, sda_oe_n);
    chk("sda_out in reset", 0, sda_out);
    chk("busy in reset", 0, write_busy);
    chk("we in reset", 0, arr_we);
    chk("addr in reset", 0, arr_addr);
  endtask : t_reset
  // Wrong code or select is ignored; read direction acked; address-only stop idles
  task automatic t_select();
    logic [2:0] smp;
    logic [7:0] bad [4];
    bad = '{{CODE ^ 4'h8, STRAPS, 1'b0}, {CODE, STRAPS ^ 3'h1, 1'b0},
            {CODE, STRAPS ^ 3'h2, 1'b0}, {CODE, STRAPS ^ 3'h4, 1'b0}};
    foreach (bad[i]) begin
      m.start_cond();
      m.send_byte(bad[i], smp);
      chk("bad ctrl nack", 3'b111, smp);
      m.stop_cond();
    end
    m.start_cond();
    m.send_byte({CODE, STRAPS, DIR_READ}, smp);
    chk("read ctrl ack", 3'b000, smp);
    m.stop_cond();
    write_seq(12'h7FF, 0, 8'h00);
    chk("no write cycle", 0, write_busy);
  endtask : t_select
  task automatic t_byte_write();
    logic [2:0] smp;
    int polls;
    seen.delete();
    write_seq(12'h123, 1, 8'hA5);
    chk("busy after stop", 1, write_busy);
    polls = 0;
    smp = 3'b111;
    while (smp !== 3'b000 && polls < 20) begin
      m.start_cond();
      m.send_byte(WR_CTRL, smp);
      m.stop_cond();
      if (polls == 0) chk("poll busy nack", 3'b111, smp);
      polls++;
    end
    chk("poll ack", 3'b000, smp);
    chk("busy at ack", 0, write_busy);
    chk("byte count", 1, seen.num());
    chk("byte data", 8'hA5, seen[12'h123]);
  endtask : t_byte_write
  // 34 bytes from slot 30 wrap inside the page and overwrite slots 30 and 31
  task automatic t_page_wrap();
    int k;
    seen.delete();
    write_seq(12'h03E, 34, 8'h40);
    wait_idle();
    chk("page count", 32, seen.num());
    for (int s = 0; s < 32; s++) begin
      k = (s + 2) % 32;
      if (k + 32 < 34) k += 32;
      chk("page data", 8'h40 + k, seen[12'h020 + 12'(s)]);
    end
  endtask : t_page_wrap
  // A repeat start in mid byte drops the partial write and begins afresh
  task automatic t_restart();
    logic [2:0] smp;
    seen.delete();
    m.start_cond();
    m.send_byte(WR_CTRL, smp);
    m.send_byte(8'h07, smp);
    m.send_byte(8'h80, smp);
    m.send_bits(8'h33, 4);
    write_seq(12'h055, 1, 8'h66);
    wait_idle();
    chk("restart count", 1, seen.num());
    chk("restart data", 8'h66, seen[12'h055]);
  endtask : t_restart
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    straps = STRAPS;
    error_cnt = 0;
    compares = 0;
    repeat (20) @(negedge mclk);
    t_reset();
    rst = 1'b0;
    repeat (8) @(negedge mclk);
    t_select();
    t_byte_write();
    t_page_wrap();
    t_restart();
    test_done();
  end
  // Cuts a hang short
  initial begin
    #500000;
    error_cnt++;
    $display("ERROR run time expected done seen hang");
    test_done();
  end
endmodule : tb_eeprom_twowire_slave
`default_nettype wire
